// ---- bench/aim_host_model.sv ----
// Host-side model that counts interrupt service requests on the lead
`timescale 1ns/10ps
`default_nettype none

module aim_host_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        irq_i,
	output logic [15:0]      service_cnt_o
);
	logic irq_prev;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			irq_prev      <= 1'b0;
			service_cnt_o <= 16'h0000;
		end
		else
		begin
			irq_prev <= irq_i;
			if (irq_i && !irq_prev)
				service_cnt_o <= service_cnt_o + 16'h0001;
		end
	end
endmodule : aim_host_model

`default_nettype wire

// ---- bench/tb_alarm_interrupt_mask_tree.sv ----
// Self-checking bench for the alarm interrupt mask tree
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_alarm_interrupt_mask_tree;
	import aim_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h1;
	logic [31:0] rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  pa = 8'h00, ind;
	logic        ef = 1'b0, ab = 1'b0, bb = 1'b0, irq;
	logic [3:0]  ra = 4'h0, rb = 4'h0, af = 4'h0, bf = 4'h0;
	logic [3:0]  ta = 4'h0, tbf = 4'h0, tx = 4'h0, rf = 4'h0;
	logic [7:0]  pm, rxm, tfm, trm, g, hw, rv;
	logic [15:0] lfsr = 16'h0054;
	logic [15:0] svc;
	int          errors = 0;
	int          compares = 0;

	always #2.5 clk_i = ~clk_i;

	aim_mask_tree #(.ADDR_W(12)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .proc_alarm_i(pa),
		.ext_clock_fail_i(ef), .a_bus_alarm_i(ab), .b_bus_alarm_i(bb),
		.rx_a_alarm_i(ra), .rx_b_alarm_i(rb), .a_side_remote_fail_alarm_i(af),
		.b_side_remote_fail_alarm_i(bf), .tx_fifo_a_alarm_i(ta), .tx_fifo_b_alarm_i(tbf),
		.tx_alarm_i(tx), .rx_fifo_err_alarm_i(rf), .irq_indication_o(ind), .irq_o(irq));

	aim_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .service_cnt_o(svc));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		for (int i = 0; i < 8; i++)
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd

	function automatic logic [7:0] exp_ind();
		logic [7:0] e;
		e = 8'h00;
		for (int n = 0; n < 4; n++)
			e[n] = g[n] & ((ra[n] & rxm[2*n+1]) | (rb[n] & rxm[2*n]) | af[n] | bf[n]
				| (ta[n] & tfm[2*n+1]) | (tbf[n] & tfm[2*n]) | (tx[n] & trm[4+n])
				| (rf[n] & trm[n]));
		e[6] = g[6] & ef;
		e[5] = g[5] & ab;
		e[4] = g[4] & bb;
		e[7] = (|e[6:0]) | (pm[0] & (pa[7] | pa[6] | pa[4]));
		return e;
	endfunction : exp_ind

	task automatic axw(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		awaddr <= {2'h0, idx, 2'h0};
		wdata  <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				r = bresp;
		end while (!bvalid && n < 40);
		if (n >= 40)
			errors++;
	endtask : axw

	task automatic axr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr  <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			d = rdata;
			r = rresp;
		end while (!rvalid && n < 40);
		if (n >= 40)
			errors++;
	endtask : axr

	task automatic wr_all();
		logic [1:0] r;
		axw(IDX_PROC_ALARM_MASK, pm, r);
		axw(IDX_RX_SIDE_MASK, rxm, r);
		axw(IDX_TX_FIFO_MASK, tfm, r);
		axw(IDX_TX_RX_FIFO_MASK, trm, r);
		axw(IDX_GROUP_IRQ_MASK, g, r);
		axw(IDX_HW_IRQ_CTRL, hw, r);
		`CHK(r, RESP_OKAY)
	endtask : wr_all

	// Event term: an enabled sticky event also holds the lead up
	task automatic check_out(input logic ev = 1'b0);
		logic [7:0] e;
		repeat (3) @(posedge clk_i);
		e = exp_ind();
		`CHK(ind, e)
		`CHK(irq, hw[0] & (e[7] | ev))
	endtask : check_out

	task automatic close_out();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [1:0]  r;
		logic [31:0] d;
		logic [7:0]  idx [6];
		idx = '{IDX_PROC_ALARM_MASK, IDX_RX_SIDE_MASK, IDX_TX_FIFO_MASK,
			IDX_TX_RX_FIFO_MASK, IDX_GROUP_IRQ_MASK, IDX_HW_IRQ_CTRL};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (idx[i])
		begin
			axr(idx[i], d, r);
			`CHK(d, 32'h0)
		end
		pm = rnd() >> 7; rxm = rnd(); tfm = rnd(); trm = rnd();
		g = rnd() & 8'h7f; hw = 8'h01;
		wr_all();
		axr(IDX_GROUP_IRQ_MASK, d, r); `CHK(d, {24'h0, g})
		axr(IDX_RX_SIDE_MASK, d, r); `CHK(d, {24'h0, rxm})
		axr(IDX_TX_FIFO_MASK, d, r); `CHK(d, {24'h0, tfm})
		axr(IDX_TX_RX_FIFO_MASK, d, r); `CHK(d, {24'h0, trm})
		axr(IDX_PROC_ALARM_MASK, d, r); `CHK(d, {24'h0, pm})
		axr(8'h3f, d, r); `CHK(r, RESP_SLVERR)
		axw(8'h3f, 8'h5a, r); `CHK(r, RESP_SLVERR)
		// Remote fail with no receive sub-mask, only group bits
		pm = 8'h00; rxm = 8'h00; tfm = 8'h00; trm = 8'h00; g = 8'h0f; hw = 8'h00;
		wr_all();
		af <= 4'h4; bf <= 4'h8;
		check_out();
		`CHK(ind[3:2], 2'h3)
		`CHK(irq, 1'b0)
		// Random masks and alarms
		for (int k = 0; k < 60; k++)
		begin
			pm = rnd() >> 7; rxm = rnd(); tfm = rnd(); trm = rnd();
			g = rnd() & 8'h7f; hw = rnd() >> 7;
			wr_all();
			pa <= rnd();
			{ra, rb} <= rnd();
			// Remote failures kept sparse so the sub-masks still matter
			{af, bf} <= rnd() & rnd();
			{ta, tbf} <= rnd();
			{tx, rf} <= rnd();
			rv = rnd();
			{ef, ab, bb} <= rv[2:0];
			check_out();
			axr(IDX_IRQ_INDICATION, d, r);
			`CHK(d, {24'h0, exp_ind()})
		end
		// Sticky events: raise, mask, clear
		{pa, ef, ab, bb, ra, rb, af, bf, ta, tbf, tx, rf} <= '0;
		pm = 8'h00; g = 8'h01; hw = 8'h01;
		wr_all();
		repeat (3) @(posedge clk_i);
		axw(IDX_EVT_CLEAR, 8'hff, r);
		axw(IDX_EVT_ENABLE, 8'h01, r);
		af <= 4'h1;
		check_out();
		af <= 4'h0;
		check_out(1'b1);
		axr(IDX_EVT_STATUS, d, r); `CHK(d, 32'h81)
		`CHK(irq, 1'b1)
		axw(IDX_EVT_ENABLE, 8'h00, r);
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b0)
		axw(IDX_EVT_ENABLE, 8'h01, r);
		axw(IDX_EVT_CLEAR, 8'h01, r);
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b0)
		axr(IDX_EVT_STATUS, d, r); `CHK(d, 32'h80)
		axr(IDX_EVT_CLEAR, d, r); `CHK(d, 32'h0)
		axw(IDX_IRQ_INDICATION, 8'hff, r); `CHK(r, RESP_OKAY)
		axr(IDX_IRQ_INDICATION, d, r); `CHK(d, 32'h0)
		// Lane zero strobe low: the write is answered but nothing is stored
		wstrb <= 4'h0;
		axw(IDX_GROUP_IRQ_MASK, 8'h7f, r);
		wstrb <= 4'h1;
		axr(IDX_GROUP_IRQ_MASK, d, r); `CHK(d, {24'h0, g})
		`CHK(svc != 16'h0, 1'b1)
		close_out();
	end

	// Hang guard well beyond the expected run length
	initial
	begin
		#(20000 * 5);
		errors++;
		close_out();
	end
endmodule : tb_alarm_interrupt_mask_tree

`default_nettype wire

// ---- verilog/aim_mask_tree.sv ----
// Alarm interrupt mask tree with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none

module aim_mask_tree
	import aim_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic [7:0]        proc_alarm_i,
	input  wire logic              ext_clock_fail_i,
	input  wire logic              a_bus_alarm_i,
	input  wire logic              b_bus_alarm_i,
	input  wire logic [3:0]        rx_a_alarm_i,
	input  wire logic [3:0]        rx_b_alarm_i,
	input  wire logic [3:0]        a_side_remote_fail_alarm_i,
	input  wire logic [3:0]        b_side_remote_fail_alarm_i,
	input  wire logic [3:0]        tx_fifo_a_alarm_i,
	input  wire logic [3:0]        tx_fifo_b_alarm_i,
	input  wire logic [3:0]        tx_alarm_i,
	input  wire logic [3:0]        rx_fifo_err_alarm_i,
	output logic [7:0]             irq_indication_o,
	output logic                   irq_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             proc_msk;
		logic [7:0]       rx_side_msk;
		logic [7:0]       tx_fifo_msk;
		logic [7:0]       tx_rx_fifo_msk;
		logic [GRP_W-1:0] grp_msk;
		logic             hw_en;
		logic [7:0]       evt_en;
		logic [7:0]       evt_sts;
		logic [7:0]       ind;
		logic             aw_held;
		logic [7:0]       aw_idx;
		logic             w_held;
		logic [7:0]       wdata;
		logic             wlane0;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [7:0]       rdata;
	} aim_state_s;

	aim_state_s st_reg;
	aim_state_s st_next;

	logic [NUM_PORTS-1:0] port_ind;
	logic                 proc_hit;
	logic [7:0]           ind_now;
	logic [7:0]           evt_clr;
	logic                 do_write;
	logic                 do_read;
	logic [7:0]           ar_idx;
	logic [7:0]           rd_byte;
	logic                 rd_hit;
	logic                 wr_hit;

	// ----------------------------------------------------------------
	// Per-port gating
	// ----------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++)
		begin : g_port
			aim_port_gate u_gate
			(
				.grp_en_i      (st_reg.grp_msk[gp]),
				.rx_a_en_i     (st_reg.rx_side_msk[2*gp+1]),
				.rx_b_en_i     (st_reg.rx_side_msk[2*gp]),
				.txf_a_en_i    (st_reg.tx_fifo_msk[2*gp+1]),
				.txf_b_en_i    (st_reg.tx_fifo_msk[2*gp]),
				.tx_en_i       (st_reg.tx_rx_fifo_msk[TX_ALARM_BASE+gp]),
				.rxf_en_i      (st_reg.tx_rx_fifo_msk[gp]),
				.rx_a_alarm_i  (rx_a_alarm_i[gp]),
				.rx_b_alarm_i  (rx_b_alarm_i[gp]),
				.a_rfi_i       (a_side_remote_fail_alarm_i[gp]),
				.b_rfi_i       (b_side_remote_fail_alarm_i[gp]),
				.txf_a_alarm_i (tx_fifo_a_alarm_i[gp]),
				.txf_b_alarm_i (tx_fifo_b_alarm_i[gp]),
				.tx_alarm_i    (tx_alarm_i[gp]),
				.rxf_alarm_i   (rx_fifo_err_alarm_i[gp]),
				.port_ind_o    (port_ind[gp])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Indication vector
	// ----------------------------------------------------------------
	// processor alarm gate
	assign proc_hit = st_reg.proc_msk
		& (proc_alarm_i[PROC_ALM_HI] | proc_alarm_i[PROC_ALM_MID]
		| proc_alarm_i[PROC_ALM_LO]);

	always_comb
	begin
		ind_now = MASK_RST;
		ind_now[NUM_PORTS-1:0] = port_ind;
		ind_now[IND_EXT_BIT] = ext_clock_fail_i & st_reg.grp_msk[GRP_EXT_BIT];
		ind_now[IND_A_BIT] = a_bus_alarm_i & st_reg.grp_msk[GRP_A_BIT];
		ind_now[IND_B_BIT] = b_bus_alarm_i & st_reg.grp_msk[GRP_B_BIT];
		ind_now[IND_SW_BIT] = proc_hit | (|ind_now[IND_EXT_BIT:0]);
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign do_write = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
	assign do_read  = s_axi_arvalid_i & ~st_reg.rvalid;
	assign ar_idx   = s_axi_araddr_i[9:2];
	assign evt_clr  = (do_write && st_reg.wlane0 && st_reg.aw_idx == IDX_EVT_CLEAR)
		? st_reg.wdata : MASK_RST;

	always_comb
	begin
		wr_hit = 1'b1;
		unique case (st_reg.aw_idx)
			IDX_PROC_ALARM_MASK, IDX_RX_SIDE_MASK, IDX_TX_FIFO_MASK,
			IDX_TX_RX_FIFO_MASK, IDX_IRQ_INDICATION, IDX_GROUP_IRQ_MASK,
			IDX_HW_IRQ_CTRL, IDX_EVT_STATUS, IDX_EVT_CLEAR, IDX_EVT_ENABLE: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Unused and reserved bits read as zero; clear register is write-only
	always_comb
	begin
		rd_byte = MASK_RST;
		rd_hit  = 1'b1;
		unique case (ar_idx)
			IDX_PROC_ALARM_MASK: rd_byte[0] = st_reg.proc_msk;
			IDX_RX_SIDE_MASK:    rd_byte = st_reg.rx_side_msk;
			IDX_TX_FIFO_MASK:    rd_byte = st_reg.tx_fifo_msk;
			IDX_TX_RX_FIFO_MASK: rd_byte = st_reg.tx_rx_fifo_msk;
			IDX_IRQ_INDICATION:  rd_byte = st_reg.ind;
			IDX_GROUP_IRQ_MASK:  rd_byte[GRP_W-1:0] = st_reg.grp_msk;
			IDX_HW_IRQ_CTRL:     rd_byte[0] = st_reg.hw_en;
			IDX_EVT_STATUS:      rd_byte = st_reg.evt_sts;
			IDX_EVT_CLEAR:       rd_byte = MASK_RST;
			IDX_EVT_ENABLE:      rd_byte = st_reg.evt_en;
			default:             rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.ind = ind_now;
		// Set wins over a clear in the same cycle
		st_next.evt_sts = (st_reg.evt_sts & ~evt_clr) | (ind_now & ~st_reg.ind);

		if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_idx  = s_axi_awaddr_i[9:2];
		end
		if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			st_next.w_held = 1'b1;
			st_next.wdata  = s_axi_wdata_i[7:0];
			st_next.wlane0 = s_axi_wstrb_i[0];
		end
		if (do_write)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (st_reg.wlane0)
			begin
				unique case (st_reg.aw_idx)
					IDX_PROC_ALARM_MASK: st_next.proc_msk = st_reg.wdata[0];
					IDX_RX_SIDE_MASK:    st_next.rx_side_msk = st_reg.wdata;
					IDX_TX_FIFO_MASK:    st_next.tx_fifo_msk = st_reg.wdata;
					IDX_TX_RX_FIFO_MASK: st_next.tx_rx_fifo_msk = st_reg.wdata;
					IDX_GROUP_IRQ_MASK:  st_next.grp_msk = st_reg.wdata[GRP_W-1:0];
					IDX_HW_IRQ_CTRL:     st_next.hw_en = st_reg.wdata[0];
					IDX_EVT_ENABLE:      st_next.evt_en = st_reg.wdata;
					default:             st_next.hw_en = st_reg.hw_en;
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready_i)
		begin
			st_next.bvalid = 1'b0;
		end

		if (st_reg.rvalid && s_axi_rready_i)
		begin
			st_next.rvalid = 1'b0;
		end
		if (do_read)
		begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_byte;
			st_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o  = ~st_reg.aw_held & ~st_reg.bvalid;
	assign s_axi_wready_o   = ~st_reg.w_held & ~st_reg.bvalid;
	assign s_axi_bvalid_o   = st_reg.bvalid;
	assign s_axi_bresp_o    = st_reg.bresp;
	assign s_axi_arready_o  = ~st_reg.rvalid;
	assign s_axi_rvalid_o   = st_reg.rvalid;
	assign s_axi_rresp_o    = st_reg.rresp;
	assign s_axi_rdata_o    = {24'h000000, st_reg.rdata};
	assign irq_indication_o = st_reg.ind;

	// enable AND indication
	// Event enables default off, so the lead follows the indication alone
	assign irq_o = st_reg.hw_en & (st_reg.ind[IND_SW_BIT] | (|(st_reg.evt_sts & st_reg.evt_en)));

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_PROC_ALARM_IRQ: assert property (
		(st_reg.proc_msk && proc_alarm_i[PROC_ALM_LO]) |=> st_reg.ind[IND_SW_BIT])
		else $error("processor alarm did not raise indication");
	AST_PROC_ALARM_MASKED: assert property (
		(!st_reg.proc_msk && ind_now[IND_EXT_BIT:0] == '0) |=> !st_reg.ind[IND_SW_BIT])
		else $error("masked processor alarm raised indication");
	AST_RX_A_GATED: assert property (
		(rx_a_alarm_i[3] && st_reg.rx_side_msk[7] && st_reg.grp_msk[3]) |=> st_reg.ind[3])
		else $error("port 4 A-side receive alarm not indicated");
	AST_RX_B_GATED: assert property (
		(rx_b_alarm_i[0] && st_reg.rx_side_msk[0] && st_reg.grp_msk[0]) |=> st_reg.ind[0])
		else $error("port 1 B-side receive alarm not indicated");
	AST_TXF_A_GATED: assert property (
		(tx_fifo_a_alarm_i[1] && st_reg.tx_fifo_msk[3] && st_reg.grp_msk[1]) |=> st_reg.ind[1])
		else $error("port 2 A-side FIFO error not indicated");
	AST_TXF_B_GATED: assert property (
		(tx_fifo_b_alarm_i[2] && st_reg.tx_fifo_msk[4] && st_reg.grp_msk[2]) |=> st_reg.ind[2])
		else $error("port 3 B-side FIFO error not indicated");
	AST_TX_ALARM_GATED: assert property (
		(tx_alarm_i[2] && st_reg.tx_rx_fifo_msk[6] && st_reg.grp_msk[2]) |=> st_reg.ind[2])
		else $error("port 3 transmit alarm not indicated");
	AST_RXF_GATED: assert property (
		(rx_fifo_err_alarm_i[3] && st_reg.tx_rx_fifo_msk[3] && st_reg.grp_msk[3]) |=> st_reg.ind[3])
		else $error("port 4 receive FIFO error not indicated");
	AST_EXT_CLOCK_FLAG: assert property (
		##1 st_reg.ind[IND_EXT_BIT] == $past(ext_clock_fail_i && st_reg.grp_msk[GRP_EXT_BIT]))
		else $error("external clock flag wrong");
	AST_A_SIDE_FLAG: assert property (
		st_reg.ind[IND_A_BIT] |-> $past(st_reg.grp_msk[GRP_A_BIT]))
		else $error("A-side flag set while masked");
	AST_B_SIDE_FLAG: assert property (
		st_reg.ind[IND_B_BIT] |-> $past(st_reg.grp_msk[GRP_B_BIT]))
		else $error("B-side flag set while masked");
	AST_PORT_NEEDS_GROUP: assert property (
		(st_reg.grp_msk[NUM_PORTS-1:0] == '0) |=> (st_reg.ind[NUM_PORTS-1:0] == '0))
		else $error("port indication with group masks clear");
	AST_RFI_BYPASS: assert property (
		(b_side_remote_fail_alarm_i[1] && st_reg.grp_msk[1]) |=> st_reg.ind[1])
		else $error("remote failure did not bypass sub-mask");
	AST_LEAD_NEEDS_ENABLE: assert property (
		!st_reg.hw_en |-> !irq_o)
		else $error("lead active without hardware enable");
	AST_SW_IND_ANY: assert property (
		(|ind_now[IND_EXT_BIT:0]) |=> st_reg.ind[IND_SW_BIT])
		else $error("indication missing for enabled alarm");
	AST_LEAD_FOLLOWS: assert property (
		(st_reg.evt_en == '0) |-> (irq_o == (st_reg.hw_en && st_reg.ind[IND_SW_BIT])))
		else $error("lead not enable AND indication");
	AST_WRITE_ANSWER: assert property (
		do_write |=> s_axi_bvalid_o)
		else $error("write not answered");

	COV_PORT_IRQ: cover property (st_reg.hw_en && st_reg.ind[0] ##1 irq_o);
	COV_RFI_PATH: cover property (a_side_remote_fail_alarm_i[0] && !st_reg.rx_side_msk[1]
		&& st_reg.grp_msk[0] ##1 st_reg.ind[0]);
	COV_EXT_CLOCK: cover property (st_reg.ind[IND_EXT_BIT] && irq_o);
	COV_EVT_CLEAR: cover property (evt_clr != '0 && st_reg.evt_sts != '0);

endmodule : aim_mask_tree

`default_nettype wire

// ---- verilog/aim_pkg.sv ----
// Package: register map and field layout of the alarm interrupt mask tree
package aim_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PROC_ALARM_MASK = 8'h16;
	localparam logic [7:0] IDX_RX_SIDE_MASK    = 8'h17;
	localparam logic [7:0] IDX_TX_FIFO_MASK    = 8'h18;
	localparam logic [7:0] IDX_TX_RX_FIFO_MASK = 8'h19;
	localparam logic [7:0] IDX_IRQ_INDICATION  = 8'h20;
	localparam logic [7:0] IDX_GROUP_IRQ_MASK  = 8'h21;
	localparam logic [7:0] IDX_HW_IRQ_CTRL     = 8'h30;
	localparam logic [7:0] IDX_EVT_STATUS      = 8'h31;
	localparam logic [7:0] IDX_EVT_CLEAR       = 8'h32;
	localparam logic [7:0] IDX_EVT_ENABLE      = 8'h33;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int NUM_PORTS     = 4;
	localparam int IND_SW_BIT    = 7;
	localparam int IND_EXT_BIT   = 6;
	localparam int IND_A_BIT     = 5;
	localparam int IND_B_BIT     = 4;
	localparam int GRP_EXT_BIT   = 6;
	localparam int GRP_A_BIT     = 5;
	localparam int GRP_B_BIT     = 4;
	localparam int TX_ALARM_BASE = 4;
	localparam int PROC_ALM_HI   = 7;
	localparam int PROC_ALM_MID  = 6;
	localparam int PROC_ALM_LO   = 4;
	localparam int GRP_W         = 7;

	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_RST    = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : aim_pkg

// ---- verilog/aim_port_gate.sv ----
// Per-port two-level mask gate producing one port indication
`timescale 1ns/10ps
`default_nettype none

module aim_port_gate
(
	input  wire logic grp_en_i,
	input  wire logic rx_a_en_i,
	input  wire logic rx_b_en_i,
	input  wire logic txf_a_en_i,
	input  wire logic txf_b_en_i,
	input  wire logic tx_en_i,
	input  wire logic rxf_en_i,
	input  wire logic rx_a_alarm_i,
	input  wire logic rx_b_alarm_i,
	input  wire logic a_rfi_i,
	input  wire logic b_rfi_i,
	input  wire logic txf_a_alarm_i,
	input  wire logic txf_b_alarm_i,
	input  wire logic tx_alarm_i,
	input  wire logic rxf_alarm_i,
	output logic      port_ind_o
);

	logic sub_hit;

	// remote fail bypass
	// Remote failure needs only the group mask, not the side sub-mask
	assign sub_hit = (rx_a_alarm_i & rx_a_en_i) | (rx_b_alarm_i & rx_b_en_i)
		| a_rfi_i | b_rfi_i
		| (txf_a_alarm_i & txf_a_en_i) | (txf_b_alarm_i & txf_b_en_i)
		| (tx_alarm_i & tx_en_i) | (rxf_alarm_i & rxf_en_i);

	assign port_ind_o = grp_en_i & sub_hit;

endmodule : aim_port_gate

`default_nettype wire
